// [hdl/clocked_serial_buffer_set.sv]
// buffer set of a clocked serial channel with an apb register slave
// assumes an external master drives the serial clock; data shifted on its edges:
// output changes on falling edge, input sampled on rising edge
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
module clocked_serial_buffer_set (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  input wire logic sckIn,
  input wire logic serialIn,
  output logic serialOut,
  // events
  output logic transferDoneEvent
);
  sync_link_if link ();
  pin_sync u_sync (
    .mclk(mclk),
    .sysRst(sys_rst),
    .clkEn(clkEn),
    .sckPin(sckIn),
    .dinPin(serialIn),
    .link(link)
  );

  typedef struct packed {
    logic channelEnable;
    logic duplexModeSelect;
    logic wordLengthSelect;
    logic lsbFirst;
    logic continuousModeSelect;
    logic transferActiveFlag;
    csb_pkg::phase_e phase;
    logic [15:0] transmitBuffer;
    logic [15:0] initialTransmitBuffer;
    logic [15:0] shiftReg;
    logic [15:0] receiveBuffer;
    logic [4:0] bitCount;
    logic pending;
    logic firstWord;
    logic sckPrev;
    logic sout;
    logic done;
    logic [31:0] rdata;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  logic apbAccess;
  logic apbWrite;
  logic apbRead;
  logic [4:0] wordLen;
  logic sckRise;
  logic sckFall;
  logic [15:0] shiftIn;
  logic [7:0] modeView;
  logic addrHit;

  assign apbAccess = psel && penable;
  assign apbWrite = apbAccess && pwrite && clkEn;
  assign apbRead = apbAccess && !pwrite && clkEn;
  assign wordLen = st_r.wordLengthSelect ? csb_pkg::LEN_LONG : csb_pkg::LEN_SHORT;
  assign sckRise = link.sckSync && !st_r.sckPrev;
  assign sckFall = !link.sckSync && st_r.sckPrev;
  assign modeView = {st_r.channelEnable, st_r.duplexModeSelect, st_r.wordLengthSelect,
                     st_r.lsbFirst, 1'b0, st_r.continuousModeSelect, 1'b0,
                     st_r.transferActiveFlag};

  // next shift value; in short words only the low byte moves
  always_comb begin
    shiftIn = st_r.shiftReg;
    if (st_r.lsbFirst) begin
      if (st_r.wordLengthSelect) begin
        shiftIn = {link.dinSync, st_r.shiftReg[15:1]};
      end else begin
        shiftIn = {8'h00, link.dinSync, st_r.shiftReg[7:1]};
      end
    end else begin
      if (st_r.wordLengthSelect) begin
        shiftIn = {st_r.shiftReg[14:0], link.dinSync};
      end else begin
        shiftIn = {8'h00, st_r.shiftReg[6:0], link.dinSync};
      end
    end
  end

  always_comb begin
    unique case (paddr)
      csb_pkg::ADDR_MODE, csb_pkg::ADDR_RX, csb_pkg::ADDR_RX_LOW, csb_pkg::ADDR_PEEK,
      csb_pkg::ADDR_PEEK_LOW, csb_pkg::ADDR_TX, csb_pkg::ADDR_TX_LOW,
      csb_pkg::ADDR_INIT_TX, csb_pkg::ADDR_INIT_TX_LOW, csb_pkg::ADDR_SHIFT,
      csb_pkg::ADDR_SHIFT_LOW: addrHit = 1'b1;
      default: addrHit = 1'b0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    if (clkEn) begin
      // pulse ends only while the clock runs; a pause holds it
      st_nxt.done = 1'b0;
      st_nxt.sckPrev = link.sckSync;
      // register reads
      if (apbRead) begin
        st_nxt.rdata = 32'h0;
        unique case (paddr)
          csb_pkg::ADDR_MODE: st_nxt.rdata = {24'h0, modeView};
          csb_pkg::ADDR_RX: st_nxt.rdata = {16'h0, st_r.receiveBuffer};
          csb_pkg::ADDR_RX_LOW: st_nxt.rdata = {24'h0, st_r.receiveBuffer[7:0]};
          csb_pkg::ADDR_PEEK: st_nxt.rdata = {16'h0, st_r.receiveBuffer};
          csb_pkg::ADDR_PEEK_LOW: st_nxt.rdata = {24'h0, st_r.receiveBuffer[7:0]};
          csb_pkg::ADDR_TX: st_nxt.rdata = {16'h0, st_r.transmitBuffer};
          csb_pkg::ADDR_TX_LOW: st_nxt.rdata = {24'h0, st_r.transmitBuffer[7:0]};
          csb_pkg::ADDR_INIT_TX: st_nxt.rdata = {16'h0, st_r.initialTransmitBuffer};
          csb_pkg::ADDR_INIT_TX_LOW: st_nxt.rdata = {24'h0, st_r.initialTransmitBuffer[7:0]};
          csb_pkg::ADDR_SHIFT: st_nxt.rdata = {16'h0, st_r.shiftReg};
          csb_pkg::ADDR_SHIFT_LOW: st_nxt.rdata = {24'h0, st_r.shiftReg[7:0]};
          default: st_nxt.rdata = 32'h0;
        endcase
        // receive reads request a word in receive-only mode
        if ((paddr == csb_pkg::ADDR_RX || paddr == csb_pkg::ADDR_RX_LOW)
            && st_r.channelEnable && !st_r.duplexModeSelect) begin
          st_nxt.pending = 1'b1;
        end
      end
      // register writes
      if (apbWrite) begin
        unique case (paddr)
          csb_pkg::ADDR_MODE: begin
            st_nxt.channelEnable = pwdata[csb_pkg::BIT_ENABLE];
            st_nxt.duplexModeSelect = pwdata[csb_pkg::BIT_DUPLEX];
            st_nxt.wordLengthSelect = pwdata[csb_pkg::BIT_LENGTH];
            st_nxt.lsbFirst = pwdata[csb_pkg::BIT_LSB_FIRST];
            st_nxt.continuousModeSelect = pwdata[csb_pkg::BIT_CONTINUOUS];
          end
          csb_pkg::ADDR_TX, csb_pkg::ADDR_TX_LOW: begin
            if (paddr == csb_pkg::ADDR_TX) begin
              st_nxt.transmitBuffer = pwdata[15:0];
            end else begin
              st_nxt.transmitBuffer = {8'h00, pwdata[7:0]};
            end
            if (st_r.channelEnable && st_r.duplexModeSelect) begin
              st_nxt.pending = 1'b1;
            end
          end
          csb_pkg::ADDR_INIT_TX: st_nxt.initialTransmitBuffer = pwdata[15:0];
          csb_pkg::ADDR_INIT_TX_LOW: begin
            st_nxt.initialTransmitBuffer = {8'h00, pwdata[7:0]};
          end
          default: ;
        endcase
      end
      // word engine
      unique case (st_r.phase)
        csb_pkg::IDLE: begin
          if (st_nxt.pending && st_nxt.channelEnable) begin
            st_nxt.pending = 1'b0;
            st_nxt.transferActiveFlag = 1'b1;
            st_nxt.bitCount = 5'h0;
            st_nxt.phase = csb_pkg::SHIFTING;
            // first continuous duplex word comes from the initial buffer
            if (!st_nxt.duplexModeSelect) begin
              st_nxt.shiftReg = csb_pkg::BUF_RESET;
            end else if (st_nxt.continuousModeSelect && st_r.firstWord) begin
              st_nxt.shiftReg = st_r.initialTransmitBuffer;
              st_nxt.pending = 1'b1;
              st_nxt.firstWord = 1'b0;
            end else begin
              st_nxt.shiftReg = st_nxt.transmitBuffer;
            end
            st_nxt.sout = 1'b0;
          end
        end
        csb_pkg::SHIFTING: begin
          if (sckFall && st_r.duplexModeSelect) begin
            // receive-only keeps the data line low
            st_nxt.sout = st_r.lsbFirst ? st_r.shiftReg[0]
                        : (st_r.wordLengthSelect ? st_r.shiftReg[15] : st_r.shiftReg[7]);
          end
          if (sckRise) begin
            st_nxt.shiftReg = shiftIn;
            st_nxt.bitCount = st_r.bitCount + 5'h1;
            if (st_r.bitCount + 5'h1 == wordLen) begin
              st_nxt.phase = csb_pkg::IDLE;
              st_nxt.transferActiveFlag = 1'b0;
              st_nxt.done = 1'b1;
              // in continuous mode the last word stays in the shift register when nothing is reserved
              if (!st_r.continuousModeSelect || st_nxt.pending) begin
                st_nxt.receiveBuffer = shiftIn;
              end
              if (!st_nxt.pending) begin
                st_nxt.firstWord = 1'b1;
              end
            end
          end
        end
        default: st_nxt.phase = csb_pkg::IDLE;
      endcase
      // leaving duplex must not strand the last sent bit on the line
      if (!st_nxt.duplexModeSelect) begin
        st_nxt.sout = 1'b0;
      end
      // a receive-only continuous run reserves the second word at its start
      if (st_r.phase == csb_pkg::IDLE && st_nxt.phase == csb_pkg::SHIFTING
          && !st_nxt.duplexModeSelect && st_nxt.continuousModeSelect && st_r.firstWord) begin
        st_nxt.pending = 1'b1;
        st_nxt.firstWord = 1'b0;
      end
      // disable clears the channel state, not the transmit buffers
      if (!st_nxt.channelEnable) begin
        st_nxt.transferActiveFlag = 1'b0;
        st_nxt.shiftReg = csb_pkg::BUF_RESET;
        st_nxt.receiveBuffer = csb_pkg::BUF_RESET;
        st_nxt.phase = csb_pkg::IDLE;
        st_nxt.pending = 1'b0;
        st_nxt.firstWord = 1'b1;
        st_nxt.sout = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.transmitBuffer <= csb_pkg::BUF_RESET;
      st_r.initialTransmitBuffer <= csb_pkg::BUF_RESET;
      st_r.shiftReg <= csb_pkg::BUF_RESET;
      st_r.firstWord <= 1'b1;
      st_r.phase <= csb_pkg::IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready = 1'b1;
  assign pslverr = apbAccess && !addrHit;
  // always_comb so a change of the stored state inside readNow re-evaluates it
  always_comb begin
    prdata = 32'h0;
    if (apbRead) begin
      prdata = readNow(paddr);
    end
  end
  assign serialOut = st_r.sout;
  assign transferDoneEvent = st_r.done;

  function automatic logic [31:0] readNow(input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0;
    unique case (a)
      csb_pkg::ADDR_MODE: v = {24'h0, modeView};
      csb_pkg::ADDR_RX, csb_pkg::ADDR_PEEK: v = {16'h0, st_r.receiveBuffer};
      csb_pkg::ADDR_RX_LOW, csb_pkg::ADDR_PEEK_LOW: v = {24'h0, st_r.receiveBuffer[7:0]};
      csb_pkg::ADDR_TX: v = {16'h0, st_r.transmitBuffer};
      csb_pkg::ADDR_TX_LOW: v = {24'h0, st_r.transmitBuffer[7:0]};
      csb_pkg::ADDR_INIT_TX: v = {16'h0, st_r.initialTransmitBuffer};
      csb_pkg::ADDR_INIT_TX_LOW: v = {24'h0, st_r.initialTransmitBuffer[7:0]};
      csb_pkg::ADDR_SHIFT: v = {16'h0, st_r.shiftReg};
      csb_pkg::ADDR_SHIFT_LOW: v = {24'h0, st_r.shiftReg[7:0]};
      default: v = 32'h0;
    endcase
    return v;
  endfunction : readNow
endmodule : clocked_serial_buffer_set

// [hdl/csb_pkg.sv]
// constants, register map and shared types of the clocked serial buffer set
// assumes an apb slave at mclk, link clock sampled as a plain input
// What this block does
// - peek receive read returns data, no start
// - duplex mode: transmit write starts transfer
// - transmit buffer 16 bits, low byte view
// - reset clears transmit and initial buffers
// - initial buffer holds first word, no start
// - initial buffer full and low views rw
// - shift register converts, reading starts nothing
// - shift view read-only, cleared by disable
// - single receive-only: receive read starts reception
// - single: peek buffer holds last word received
// - continuous: shift register keeps final word
// - continuous receive-only: peek holds next-to-last
// - length bit: 0 eight, 1 sixteen bits
// - duplex bit: 0 receive-only, 1 duplex
// - auto bit: 0 single, 1 continuous
// - active flag set during transfer, cleared disable
package csb_pkg;
  localparam logic [11:0] ADDR_MODE = 12'h000;
  localparam logic [11:0] ADDR_RX = 12'h004;
  localparam logic [11:0] ADDR_RX_LOW = 12'h008;
  localparam logic [11:0] ADDR_PEEK = 12'h00c;
  localparam logic [11:0] ADDR_PEEK_LOW = 12'h010;
  localparam logic [11:0] ADDR_TX = 12'h014;
  localparam logic [11:0] ADDR_TX_LOW = 12'h018;
  localparam logic [11:0] ADDR_INIT_TX = 12'h01c;
  localparam logic [11:0] ADDR_INIT_TX_LOW = 12'h020;
  localparam logic [11:0] ADDR_SHIFT = 12'h024;
  localparam logic [11:0] ADDR_SHIFT_LOW = 12'h028;
  localparam int BIT_ENABLE = 7;
  localparam int BIT_DUPLEX = 6;
  localparam int BIT_LENGTH = 5;
  localparam int BIT_LSB_FIRST = 4;
  localparam int BIT_CONTINUOUS = 2;
  localparam int BIT_ACTIVE = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MODE_WR_MASK = 8'hf4;
  localparam logic [15:0] BUF_RESET = 16'h0000;
  localparam logic [4:0] LEN_SHORT = 5'h08;
  localparam logic [4:0] LEN_LONG = 5'h10;
  typedef enum logic [1:0] {IDLE, SHIFTING} phase_e;
endpackage : csb_pkg

// [hdl/sync_link_if.sv]
// carrier between top and link synchroniser
// assumes both ends run on mclk
`timescale 1ns/1ps
interface sync_link_if;
  logic sckSync;
  logic dinSync;
  modport core (input sckSync, input dinSync);
  modport sync (output sckSync, output dinSync);
endinterface : sync_link_if

// [hdl/pin_sync.sv]
// two-flop synchronisers for the serial clock and data pins
// assumes pins are asynchronous to mclk
`timescale 1ns/1ps
module pin_sync (
  // clock and control
  input wire logic mclk,
  input wire logic sysRst,
  input wire logic clkEn,
  // raw pins
  input wire logic sckPin,
  input wire logic dinPin,
  // synchronised
  sync_link_if.sync link
);
  typedef struct packed {
    logic [1:0] sck;
    logic [1:0] din;
  } sync_s;
  sync_s st_r;
  sync_s st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (clkEn) begin
      st_nxt.sck = {st_r.sck[0], sckPin};
      st_nxt.din = {st_r.din[0], dinPin};
    end
  end
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign link.sckSync = st_r.sck[1];
  assign link.dinSync = st_r.din[1];
endmodule : pin_sync

// [tb/csb_checker.sv]
// port assertions for the clocked serial buffer set
// assumes a bind to the top module, one mclk domain
`timescale 1ns/1ps
module csb_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // link
  input wire logic sckIn,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic transferDoneEvent
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic acc;
  logic lowView;
  logic enR;
  logic duplexR;
  assign acc = psel && penable;
  assign lowView = paddr inside {csb_pkg::ADDR_RX_LOW, csb_pkg::ADDR_PEEK_LOW,
    csb_pkg::ADDR_TX_LOW, csb_pkg::ADDR_INIT_TX_LOW, csb_pkg::ADDR_SHIFT_LOW};
  // mode shadow, only what the link outputs depend on
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      enR <= 1'b0;
      duplexR <= 1'b0;
    end else if (acc && pwrite && paddr == csb_pkg::ADDR_MODE) begin
      enR <= pwdata[csb_pkg::BIT_ENABLE];
      duplexR <= pwdata[csb_pkg::BIT_DUPLEX];
    end
  end
  a_zero_wait: assert property (acc |-> pready) else $error("no ready");
  a_unmapped_err: assert property (acc && paddr > csb_pkg::ADDR_SHIFT_LOW |-> pslverr
    && prdata == 32'h0) else $error("unmapped not refused");
  a_mapped_ok: assert property (acc && paddr <= csb_pkg::ADDR_SHIFT_LOW && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("mapped refused");
  a_idle_rdata: assert property (!acc |-> prdata == 32'h0) else $error("rdata outside access");
  a_low_view: assert property (acc && !pwrite && lowView |-> prdata[31:8] == 24'h0)
    else $error("low view wide");
  a_done_pulse: assert property (transferDoneEvent && clkEn |=> !transferDoneEvent)
    else $error("done not a pulse");
  a_reset_quiet: assert property ($past(sys_rst) |-> !transferDoneEvent && !serialOut)
    else $error("outputs after reset");
  a_rxonly_low: assert property (!duplexR [*3] |-> !serialOut)
    else $error("data out in receive-only");
  a_off_silent: assert property (!enR [*8] |-> !transferDoneEvent)
    else $error("done while disabled");
  c_done: cover property (transferDoneEvent);
  c_refused: cover property (acc && pslverr);
  c_low_read: cover property (acc && !pwrite && lowView);
endmodule : csb_checker

// [tb/serial_master_model.sv]
// external serial master: makes the link clock and the data into the block
// assumes msb-first words; clock idles high and stands still between frames
`timescale 1ns/1ps
module serial_master_model (
  // link
  output logic sck,
  output logic sdo,
  input wire logic sdi
);
  initial begin
    sck = 1'b1;
    sdo = 1'b0;
  end
  // data changes on falling sck, both sides sample on rising sck
  task automatic xfer(input int n, input logic [15:0] din, output logic [15:0] dout);
    dout = 16'h0000;
    // keep link edges off the mclk edges
    #1;
    for (int i = n - 1; i >= 0; i--) begin
      sck = 1'b0;
      sdo = din[i];
      #62.5;
      sck = 1'b1;
      dout[i] = sdi;
      #62.5;
    end
    sdo = ~sdo; // no stale bit after the frame
  endtask : xfer
endmodule : serial_master_model

// [tb/clocked_serial_buffer_set_tb_top.sv]
// self-checking bench: apb master, serial master model, read scoreboard
// assumes zero-wait apb answers and msb-first link words
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module clocked_serial_buffer_set_tb_top;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sck, sdo, serialOut, transferDoneEvent;
  int n_errors = 0;
  int comparisons = 0;
  int doneCnt = 0;
  logic [32:0] expQ[$];
  logic [32:0] expNow;
  logic [15:0] txA, txB, rxA, rxB, got;
  always #2.5 mclk = ~mclk;
  clocked_serial_buffer_set u_clocked_serial_buffer_set (.mclk(mclk), .sys_rst(sys_rst),
    .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sckIn(sck),
    .serialIn(sdo), .serialOut(serialOut), .transferDoneEvent(transferDoneEvent));
  serial_master_model u_serial_master_model (.sck(sck), .sdo(sdo), .sdi(serialOut));
  // oldest note against each read answer
  always @(posedge mclk) begin
    if (transferDoneEvent === 1'b1) doneCnt++;
    if (psel && penable && !pwrite && pready) begin
      // pop once: the macro names its expected value twice
      expNow = expQ.pop_front();
      `CHK({pslverr, prdata}, expNow)
    end
  end
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expQ.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask : rd
  task automatic word(input int n, input logic [15:0] din, input logic [15:0] e);
    u_serial_master_model.xfer(n, din, got);
    `CHK(got, e)
  endtask : word
  task automatic wait_done(input int n);
    int k;
    k = 0;
    while (doneCnt < n && k < 200) begin
      @(posedge mclk);
      k++;
    end
    `CHK(doneCnt, n)
  endtask : wait_done
  task automatic report_and_stop();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h4203));
    txA = 16'($urandom());
    txB = 16'($urandom());
    rxA = 16'($urandom());
    rxB = 16'($urandom());
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(csb_pkg::ADDR_TX, 32'h0);
    rd(csb_pkg::ADDR_INIT_TX, 32'h0);
    wr(csb_pkg::ADDR_MODE, 32'ha0);
    wr(csb_pkg::ADDR_INIT_TX, {16'h0, txA});
    wr(csb_pkg::ADDR_SHIFT, 32'hffff);
    rd(csb_pkg::ADDR_INIT_TX, {16'h0, txA});
    rd(csb_pkg::ADDR_SHIFT, 32'h0);
    rd(csb_pkg::ADDR_MODE, 32'ha0);
    wr(12'h02c, 32'h1);
    rd(12'h02c, 33'h1_0000_0000);
    // single duplex, 16 bits
    wr(csb_pkg::ADDR_MODE, 32'he0);
    wr(csb_pkg::ADDR_TX, {16'h0, txB});
    rd(csb_pkg::ADDR_MODE, 32'he1);
    word(16, rxA, txB);
    wait_done(1);
    rd(csb_pkg::ADDR_MODE, 32'he0);
    rd(csb_pkg::ADDR_RX, {16'h0, rxA});
    rd(csb_pkg::ADDR_PEEK, {16'h0, rxA});
    rd(csb_pkg::ADDR_SHIFT, {16'h0, rxA});
    rd(csb_pkg::ADDR_MODE, 32'he0);
    // single receive-only, 8 bits: dummy read starts it
    wr(csb_pkg::ADDR_MODE, 32'h80);
    rd(csb_pkg::ADDR_RX_LOW, {24'h0, rxA[7:0]});
    rd(csb_pkg::ADDR_MODE, 32'h81);
    word(8, rxB, 16'h0);
    wait_done(2);
    rd(csb_pkg::ADDR_PEEK_LOW, {24'h0, rxB[7:0]});
    rd(csb_pkg::ADDR_MODE, 32'h80);
    // continuous duplex: initial word first, then transmit word
    wr(csb_pkg::ADDR_MODE, 32'hc4);
    wr(csb_pkg::ADDR_INIT_TX_LOW, {24'h0, txA[7:0]});
    rd(csb_pkg::ADDR_MODE, 32'hc4);
    wr(csb_pkg::ADDR_TX_LOW, {24'h0, txB[7:0]});
    word(8, rxA, {8'h0, txA[7:0]});
    wait_done(3);
    word(8, rxB, {8'h0, txB[7:0]});
    wait_done(4);
    rd(csb_pkg::ADDR_RX_LOW, {24'h0, rxA[7:0]});
    rd(csb_pkg::ADDR_SHIFT_LOW, {24'h0, rxB[7:0]});
    // continuous receive-only: one dummy read reserves two words
    wr(csb_pkg::ADDR_MODE, 32'h84);
    rd(csb_pkg::ADDR_RX_LOW, {24'h0, rxA[7:0]});
    word(8, rxB, 16'h0);
    wait_done(5);
    word(8, rxA, 16'h0);
    wait_done(6);
    rd(csb_pkg::ADDR_PEEK_LOW, {24'h0, rxB[7:0]});
    rd(csb_pkg::ADDR_SHIFT_LOW, {24'h0, rxA[7:0]});
    // disable clears the receive side, keeps transmit data
    wr(csb_pkg::ADDR_MODE, 32'h04);
    rd(csb_pkg::ADDR_SHIFT_LOW, 32'h0);
    rd(csb_pkg::ADDR_PEEK_LOW, 32'h0);
    rd(csb_pkg::ADDR_TX_LOW, {24'h0, txB[7:0]});
    // a clock-enable pause must leave the mode register as it was
    clkEn <= 1'b0;
    repeat (4) @(posedge mclk);
    clkEn <= 1'b1;
    rd(csb_pkg::ADDR_MODE, 32'h04);
    report_and_stop();
  end
endmodule : clocked_serial_buffer_set_tb_top
bind clocked_serial_buffer_set csb_checker u_csb_checker (.mclk(mclk), .sys_rst(sys_rst),
  .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sckIn(sckIn),
  .serialIn(serialIn), .serialOut(serialOut), .transferDoneEvent(transferDoneEvent));
